//--- core/anm_regs.sv
// Operation
// - Next-page word: bit 15 more pages, bit 13 message page, 11-bit code resets to one.
// - Bit 12 of next-page word: writable will-comply flag, resets to zero.
// - Read-only toggle bit 11 is inverse of last sent toggle, resets zero.
// - Received next-page register is read-only, resets zero, shows partner page fields.
// - Three-bit transmitter test field selects normal, waveform, master or slave jitter.
// - Test mode is entered only once automatic crossover is disabled.
// - Manual master/slave enable resets zero on hardware reset, kept on software reset.
// - Manual value: master one, slave zero; resets one; used only when manual enabled.
// - Port type prefers master or slave; resets one; used only when manual disabled.
// - Full-duplex advertisement resets one on hardware reset, kept on software reset.
// - Half-duplex advertisement resets zero, kept on software reset, applies after restart.
// - Role and advertisement changes take effect only at negotiation restart.
// - Restart happens when software sets restart bit or link goes down.
// - Flag configuration fault when both ends are forced to the same role.
`timescale 1ns/100ps
`include "anm_cfg.svh"

module anm_regs
    import anm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              SYS_CLK_IN,
    input  wire logic              RST_N_IN,
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
    input  wire logic              S_AXI_AWVALID_IN,
    output logic                   S_AXI_AWREADY_OUT,
    input  wire logic [31:0]       S_AXI_WDATA_IN,
    input  wire logic [3:0]        S_AXI_WSTRB_IN,
    input  wire logic              S_AXI_WVALID_IN,
    output logic                   S_AXI_WREADY_OUT,
    output logic [1:0]             S_AXI_BRESP_OUT,
    output logic                   S_AXI_BVALID_OUT,
    input  wire logic              S_AXI_BREADY_IN,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
    input  wire logic              S_AXI_ARVALID_IN,
    output logic                   S_AXI_ARREADY_OUT,
    output logic [31:0]            S_AXI_RDATA_OUT,
    output logic [1:0]             S_AXI_RRESP_OUT,
    output logic                   S_AXI_RVALID_OUT,
    input  wire logic              S_AXI_RREADY_IN,
    input  wire logic              LINK_UP_IN,
    input  wire logic              NP_SENT_IN,
    input  wire logic              RX_PAGE_VALID_IN,
    input  wire logic [15:0]       RX_PAGE_IN,
    input  wire logic              PARTNER_FORCED_IN,
    input  wire logic              PARTNER_MASTER_IN,
    output logic [15:0]            TX_NP_WORD_OUT,
    output logic                   ANEG_RESTART_OUT,
    output logic                   MANUAL_EN_OUT,
    output logic                   MANUAL_MASTER_OUT,
    output logic                   PREFER_MASTER_OUT,
    output logic                   ADV_FULL_OUT,
    output logic                   ADV_HALF_OUT,
    output logic [2:0]             TX_TEST_MODE_OUT,
    output logic [1:0]             XOVER_MODE_OUT,
    output logic                   MS_FAULT_OUT
);

    // ------------------------------------------------------------------------
    // Hardware reset image
    // ------------------------------------------------------------------------
    localparam anm_bank_t BANK_RST = '{
        link_sync:     3'h0,
        link_up:       1'b0,
        np_more:       1'b0,
        np_msg:        `ANM_NP_MSG_RST,
        np_ack2:       1'b0,
        np_toggle:     1'b0,
        np_code:       `ANM_NP_CODE_RST,
        rx_page:       16'h0000,
        test_mode:     `ANM_TM_NORMAL,
        man_en:        1'b0,
        man_val:       `ANM_MAN_VAL_RST,
        port_type:     `ANM_PORT_RST,
        adv_full:      `ANM_FULL_RST,
        adv_half:      1'b0,
        act_man_en:    1'b0,
        act_man_val:   `ANM_MAN_VAL_RST,
        act_port_type: `ANM_PORT_RST,
        act_full:      `ANM_FULL_RST,
        act_half:      1'b0,
        xover_pend:    `ANM_XO_AUTO,
        xover_act:     `ANM_XO_AUTO,
        test_out:      `ANM_TM_NORMAL,
        ms_fault:      1'b0,
        restart:       1'b0
    };

    anm_bank_t s;
    anm_bank_t next_s;

    logic                  wr_en;
    logic [`ANM_IDX_W-1:0] wr_idx;
    logic [15:0]           wr_data;
    logic [15:0]           wr_mask;
    logic                  wr_hit;
    logic                  rd_en;
    logic [`ANM_IDX_W-1:0] rd_idx;
    logic [15:0]           rd_data;
    logic                  rd_hit;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    // Reserved bit 14 stays zero
    function automatic logic [15:0] np_word(input anm_bank_t b);
        logic [15:0] w;
        w = 16'h0000;
        w[`ANM_NP_MORE] = b.np_more;
        w[`ANM_NP_MSG] = b.np_msg;
        w[`ANM_NP_ACK2] = b.np_ack2;
        w[`ANM_NP_TOG] = b.np_toggle;
        w[`ANM_NP_CODE_HI:`ANM_NP_CODE_LO] = b.np_code;
        np_word = w;
    endfunction

    function automatic logic [15:0] ms_word(input anm_bank_t b);
        logic [15:0] w;
        w = 16'h0000;
        w[`ANM_MS_TEST_HI:`ANM_MS_TEST_LO] = b.test_mode;
        w[`ANM_MS_MAN_EN] = b.man_en;
        w[`ANM_MS_MAN_VAL] = b.man_val;
        w[`ANM_MS_PORT] = b.port_type;
        w[`ANM_MS_FULL] = b.adv_full;
        w[`ANM_MS_HALF] = b.adv_half;
        ms_word = w;
    endfunction

    function automatic logic idx_known(input logic [`ANM_IDX_W-1:0] i);
        idx_known = (i == `ANM_IDX_CTRL) || (i == `ANM_IDX_NPTX) ||
                    (i == `ANM_IDX_NPRX) || (i == `ANM_IDX_MSCTL) ||
                    (i == `ANM_IDX_STAT) || (i == `ANM_IDX_XOVER);
    endfunction

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    anm_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_bus (
        .clk_in      (SYS_CLK_IN),
        .rst_n_in    (RST_N_IN),
        .awaddr_in   (S_AXI_AWADDR_IN),
        .awvalid_in  (S_AXI_AWVALID_IN),
        .awready_out (S_AXI_AWREADY_OUT),
        .wdata_in    (S_AXI_WDATA_IN),
        .wstrb_in    (S_AXI_WSTRB_IN),
        .wvalid_in   (S_AXI_WVALID_IN),
        .wready_out  (S_AXI_WREADY_OUT),
        .bresp_out   (S_AXI_BRESP_OUT),
        .bvalid_out  (S_AXI_BVALID_OUT),
        .bready_in   (S_AXI_BREADY_IN),
        .araddr_in   (S_AXI_ARADDR_IN),
        .arvalid_in  (S_AXI_ARVALID_IN),
        .arready_out (S_AXI_ARREADY_OUT),
        .rdata_out   (S_AXI_RDATA_OUT),
        .rresp_out   (S_AXI_RRESP_OUT),
        .rvalid_out  (S_AXI_RVALID_OUT),
        .rready_in   (S_AXI_RREADY_IN),
        .wr_en_out   (wr_en),
        .wr_idx_out  (wr_idx),
        .wr_data_out (wr_data),
        .wr_mask_out (wr_mask),
        .wr_hit_in   (wr_hit),
        .rd_en_out   (rd_en),
        .rd_idx_out  (rd_idx),
        .rd_data_in  (rd_data),
        .rd_hit_in   (rd_hit)
    );

    assign wr_hit = idx_known(wr_idx);
    assign rd_hit = idx_known(rd_idx);

    // ------------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------------
    always_comb begin
        rd_data = 16'h0000;
        unique case (rd_idx)
            `ANM_IDX_NPTX:  rd_data = np_word(s);
            `ANM_IDX_NPRX:  rd_data = s.rx_page;
            `ANM_IDX_MSCTL: rd_data = ms_word(s);
            `ANM_IDX_STAT: begin
                rd_data[`ANM_ST_FAULT] = s.ms_fault;
                rd_data[`ANM_ST_LINK] = s.link_up;
            end
            `ANM_IDX_XOVER: rd_data[`ANM_XO_HI:`ANM_XO_LO] = s.xover_pend;
            // Control bits are self-clearing, so they read zero
            default:        rd_data = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------------------
    // Bank update
    // ------------------------------------------------------------------------
    logic        link_fall;
    logic        sw_restart;
    logic        sw_reset;
    logic [15:0] merged;
    logic        fault_set;

    always_comb begin
        next_s = s;
        sw_restart = 1'b0;
        sw_reset = 1'b0;
        merged = 16'h0000;

        // Link pin: only the second and third stages are compared
        next_s.link_sync = {s.link_sync[1:0], LINK_UP_IN};
        if (s.link_sync[2] == s.link_sync[1]) begin
            next_s.link_up = s.link_sync[1];
        end
        link_fall = s.link_up && !next_s.link_up;

        // Each sent page flips the toggle for the next one
        if (NP_SENT_IN) begin
            next_s.np_toggle = ~s.np_toggle;
        end
        if (RX_PAGE_VALID_IN) begin
            next_s.rx_page = RX_PAGE_IN;
        end

        if (wr_en) begin
            unique case (wr_idx)
                `ANM_IDX_CTRL: begin
                    sw_restart = wr_data[`ANM_CTL_RESTART] && wr_mask[`ANM_CTL_RESTART];
                    sw_reset = wr_data[`ANM_CTL_SWRST] && wr_mask[`ANM_CTL_SWRST];
                end
                `ANM_IDX_NPTX: begin
                    merged = merge(np_word(s), wr_data, wr_mask);
                    next_s.np_more = merged[`ANM_NP_MORE];
                    next_s.np_msg = merged[`ANM_NP_MSG];
                    next_s.np_ack2 = merged[`ANM_NP_ACK2];
                    next_s.np_code = merged[`ANM_NP_CODE_HI:`ANM_NP_CODE_LO];
                end
                `ANM_IDX_MSCTL: begin
                    merged = merge(ms_word(s), wr_data, wr_mask);
                    next_s.test_mode = merged[`ANM_MS_TEST_HI:`ANM_MS_TEST_LO];
                    next_s.man_en = merged[`ANM_MS_MAN_EN];
                    next_s.man_val = merged[`ANM_MS_MAN_VAL];
                    next_s.port_type = merged[`ANM_MS_PORT];
                    next_s.adv_full = merged[`ANM_MS_FULL];
                    next_s.adv_half = merged[`ANM_MS_HALF];
                end
                `ANM_IDX_XOVER: begin
                    merged = merge({9'h000, s.xover_pend, 5'h00}, wr_data, wr_mask);
                    next_s.xover_pend = merged[`ANM_XO_HI:`ANM_XO_LO];
                end
                default: begin
                    merged = 16'h0000;
                end
            endcase
        end

        // Pending role and advertisement settings go live only here
        next_s.restart = sw_restart || link_fall;
        if (sw_restart || link_fall) begin
            next_s.act_man_en = s.man_en;
            next_s.act_man_val = s.man_val;
            next_s.act_port_type = s.port_type;
            next_s.act_full = s.adv_full;
            next_s.act_half = s.adv_half;
        end

        // Software reset: role and advertisement bits are retained
        if (sw_reset) begin
            next_s.np_more = 1'b0;
            next_s.np_msg = `ANM_NP_MSG_RST;
            next_s.np_ack2 = 1'b0;
            next_s.np_toggle = 1'b0;
            next_s.np_code = `ANM_NP_CODE_RST;
            next_s.rx_page = 16'h0000;
            next_s.test_mode = `ANM_TM_NORMAL;
            next_s.xover_act = s.xover_pend;
        end

        // Test pattern held off while automatic crossover is still active
        next_s.test_out = (next_s.xover_act != `ANM_XO_AUTO) ?
                          next_s.test_mode : `ANM_TM_NORMAL;

        // Set beats the clear-on-read in the same cycle
        fault_set = s.act_man_en && PARTNER_FORCED_IN &&
                    (s.act_man_val == PARTNER_MASTER_IN);
        if (rd_en && rd_idx == `ANM_IDX_STAT) begin
            next_s.ms_fault = 1'b0;
        end
        if (fault_set) begin
            next_s.ms_fault = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            s <= BANK_RST;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign TX_NP_WORD_OUT    = np_word(s);
    assign ANEG_RESTART_OUT  = s.restart;
    assign MANUAL_EN_OUT     = s.act_man_en;
    // Value used only with manual enable, port type only without
    assign MANUAL_MASTER_OUT = s.act_man_en && s.act_man_val;
    assign PREFER_MASTER_OUT = !s.act_man_en && s.act_port_type;
    assign ADV_FULL_OUT      = s.act_full;
    assign ADV_HALF_OUT      = s.act_half;
    assign TX_TEST_MODE_OUT  = s.test_out;
    assign XOVER_MODE_OUT    = s.xover_act;
    assign MS_FAULT_OUT      = s.ms_fault;

endmodule

//--- inc/anm_cfg.svh
`ifndef ANM_CFG_SVH
`define ANM_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------------------------------------------
`define ANM_IDX_W        8
`define ANM_IDX_CTRL     8'h00
`define ANM_IDX_NPTX     8'h07
`define ANM_IDX_NPRX     8'h08
`define ANM_IDX_MSCTL    8'h09
`define ANM_IDX_STAT     8'h0a
`define ANM_IDX_XOVER    8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ANM_CTL_SWRST    15
`define ANM_CTL_RESTART  9
`define ANM_NP_MORE      15
`define ANM_NP_MSG       13
`define ANM_NP_ACK2      12
`define ANM_NP_TOG       11
`define ANM_NP_CODE_HI   10
`define ANM_NP_CODE_LO   0
`define ANM_MS_TEST_HI   15
`define ANM_MS_TEST_LO   13
`define ANM_MS_MAN_EN    12
`define ANM_MS_MAN_VAL   11
`define ANM_MS_PORT      10
`define ANM_MS_FULL      9
`define ANM_MS_HALF      8
`define ANM_ST_FAULT     15
`define ANM_ST_LINK      2
`define ANM_XO_HI        6
`define ANM_XO_LO        5

// ----------------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------------
`define ANM_NP_CODE_RST  11'h001
`define ANM_NP_MSG_RST   1'b1
`define ANM_MAN_VAL_RST  1'b1
`define ANM_PORT_RST     1'b1
`define ANM_FULL_RST     1'b1
`define ANM_TM_NORMAL    3'h0
`define ANM_TM_WAVEFORM  3'h1
`define ANM_TM_JIT_MSTR  3'h2
`define ANM_TM_JIT_SLV   3'h3
`define ANM_XO_AUTO      2'h3
`define ANM_RESP_OKAY    2'h0
`define ANM_RESP_SLVERR  2'h2

`endif

//--- inc/anm_pkg.sv
`include "anm_cfg.svh"

package anm_pkg;

    // ------------------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic                  aw_got;
        logic [`ANM_IDX_W-1:0] aw_idx;
        logic                  aw_ok;
        logic                  w_got;
        logic [15:0]           wdata;
        logic [15:0]           wmask;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } anm_axil_t;

    // ------------------------------------------------------------------------
    // Register bank state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  link_sync;
        logic        link_up;
        logic        np_more;
        logic        np_msg;
        logic        np_ack2;
        logic        np_toggle;
        logic [10:0] np_code;
        logic [15:0] rx_page;
        logic [2:0]  test_mode;
        logic        man_en;
        logic        man_val;
        logic        port_type;
        logic        adv_full;
        logic        adv_half;
        logic        act_man_en;
        logic        act_man_val;
        logic        act_port_type;
        logic        act_full;
        logic        act_half;
        logic [1:0]  xover_pend;
        logic [1:0]  xover_act;
        logic [2:0]  test_out;
        logic        ms_fault;
        logic        restart;
    } anm_bank_t;

endpackage

//--- core/anm_axil_slave.sv
`timescale 1ns/100ps
`include "anm_cfg.svh"

module anm_axil_slave
    import anm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic [ADDR_W-1:0]     awaddr_in,
    input  wire logic                  awvalid_in,
    output logic                       awready_out,
    input  wire logic [31:0]           wdata_in,
    input  wire logic [3:0]            wstrb_in,
    input  wire logic                  wvalid_in,
    output logic                       wready_out,
    output logic [1:0]                 bresp_out,
    output logic                       bvalid_out,
    input  wire logic                  bready_in,
    input  wire logic [ADDR_W-1:0]     araddr_in,
    input  wire logic                  arvalid_in,
    output logic                       arready_out,
    output logic [31:0]                rdata_out,
    output logic [1:0]                 rresp_out,
    output logic                       rvalid_out,
    input  wire logic                  rready_in,
    output logic                       wr_en_out,
    output logic [`ANM_IDX_W-1:0]      wr_idx_out,
    output logic [15:0]                wr_data_out,
    output logic [15:0]                wr_mask_out,
    input  wire logic                  wr_hit_in,
    output logic                       rd_en_out,
    output logic [`ANM_IDX_W-1:0]      rd_idx_out,
    input  wire logic [15:0]           rd_data_in,
    input  wire logic                  rd_hit_in
);

    anm_axil_t s;
    anm_axil_t next_s;
    logic      rd_upper_ok;

    // Bits above the index window must be zero, else the access is unmapped
    function automatic logic upper_zero(input logic [ADDR_W-1:0] a);
        upper_zero = (a >> (`ANM_IDX_W + 2)) == '0;
    endfunction

    assign awready_out = !s.aw_got && !s.bvalid;
    assign wready_out  = !s.w_got && !s.bvalid;
    assign arready_out = !s.rvalid;
    assign bvalid_out  = s.bvalid;
    assign bresp_out   = s.bresp;
    assign rvalid_out  = s.rvalid;
    assign rdata_out   = s.rdata;
    assign rresp_out   = s.rresp;
    assign wr_idx_out  = s.aw_idx;
    assign wr_data_out = s.wdata;
    assign wr_mask_out = s.wmask;
    assign wr_en_out   = s.aw_got && s.w_got && !s.bvalid && s.aw_ok;
    assign rd_idx_out  = araddr_in[`ANM_IDX_W+1:2];
    assign rd_upper_ok = upper_zero(araddr_in);
    assign rd_en_out   = arvalid_in && arready_out && rd_upper_ok;

    always_comb begin
        next_s = s;
        if (awvalid_in && awready_out) begin
            next_s.aw_got = 1'b1;
            next_s.aw_idx = awaddr_in[`ANM_IDX_W+1:2];
            next_s.aw_ok  = upper_zero(awaddr_in);
        end
        if (wvalid_in && wready_out) begin
            next_s.w_got = 1'b1;
            next_s.wdata = wdata_in[15:0];
            next_s.wmask = {{8{wstrb_in[1]}}, {8{wstrb_in[0]}}};
        end
        // Response only once both halves of the write are in
        if (s.aw_got && s.w_got && !s.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = (s.aw_ok && wr_hit_in) ? `ANM_RESP_OKAY : `ANM_RESP_SLVERR;
        end
        if (s.bvalid && bready_in) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && rready_in) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid_in && arready_out) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = {16'h0000, (rd_upper_ok && rd_hit_in) ? rd_data_in : 16'h0000};
            next_s.rresp  = (rd_upper_ok && rd_hit_in) ? `ANM_RESP_OKAY : `ANM_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule

//--- verif/anm_lp_model.sv
`timescale 1ns/100ps
module anm_lp_model (
    input  wire logic        clk_in,
    input  wire logic        go_in,
    input  wire logic [15:0] page_in,
    output logic             np_sent_out,
    output logic             rx_valid_out,
    output logic [15:0]      rx_page_out
);
    initial begin
        np_sent_out = 1'h0;
        rx_valid_out = 1'h0;
        rx_page_out = 16'h0;
    end
    // Our page leaves, the partner's page lands a cycle later
    always @(posedge clk_in) begin
        np_sent_out <= go_in;
        rx_valid_out <= np_sent_out;
        // Garbage off the strobe so a missed qualifier shows
        rx_page_out <= np_sent_out ? page_in : ~rx_page_out;
    end
endmodule

//--- verif/anm_regs_chk.sv
`timescale 1ns/100ps
module anm_chk (
    input wire logic        SYS_CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic        NP_SENT_IN,
    input wire logic        LINK_UP_IN,
    input wire logic        PARTNER_FORCED_IN,
    input wire logic        PARTNER_MASTER_IN,
    input wire logic [15:0] TX_NP_WORD_OUT,
    input wire logic        ANEG_RESTART_OUT,
    input wire logic        MANUAL_EN_OUT,
    input wire logic        MANUAL_MASTER_OUT,
    input wire logic        PREFER_MASTER_OUT,
    input wire logic        ADV_FULL_OUT,
    input wire logic [2:0]  TX_TEST_MODE_OUT,
    input wire logic [1:0]  XOVER_MODE_OUT,
    input wire logic        MS_FAULT_OUT
);
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Sync chain needs two low samples before the drop counts
    sequence s_fall; $fell(LINK_UP_IN) ##1 !LINK_UP_IN [*3]; endsequence
    property p_lnk; s_fall |-> ##[1:6] ANEG_RESTART_OUT; endproperty
    property p_tog; NP_SENT_IN |=> TX_NP_WORD_OUT[11] != $past(TX_NP_WORD_OUT[11]); endproperty
    property p_b14; TX_NP_WORD_OUT[14] == 1'h0; endproperty
    property p_tm; XOVER_MODE_OUT == 2'h3 && $past(XOVER_MODE_OUT) == 2'h3 |-> !TX_TEST_MODE_OUT;
    endproperty
    property p_mm; MANUAL_MASTER_OUT |-> MANUAL_EN_OUT; endproperty
    property p_pm; PREFER_MASTER_OUT |-> !MANUAL_EN_OUT; endproperty
    property p_stb; !ANEG_RESTART_OUT |->
        $stable({MANUAL_EN_OUT, MANUAL_MASTER_OUT, PREFER_MASTER_OUT, ADV_FULL_OUT}); endproperty
    property p_flt; MANUAL_EN_OUT && PARTNER_FORCED_IN && MANUAL_MASTER_OUT == PARTNER_MASTER_IN
        |=> MS_FAULT_OUT; endproperty
    a_lnk: assert property (p_lnk) else $error("no restart on link drop");
    a_tog: assert property (p_tog) else $error("toggle not flipped");
    a_b14: assert property (p_b14) else $error("bit 14 set");
    a_tm: assert property (p_tm) else $error("test mode with auto crossover");
    a_mm: assert property (p_mm) else $error("manual master without enable");
    a_pm: assert property (p_pm) else $error("port type used in manual");
    a_stb: assert property (p_stb) else $error("role changed without restart");
    a_flt: assert property (p_flt) else $error("fault not flagged");
endmodule
bind anm_regs anm_chk anm_chk_inst (.*);

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic        SYS_CLK_IN = 1'h0, RST_N_IN = 1'h0, LINK_UP_IN = 1'h1, go = 1'h0;
    logic        S_AXI_AWVALID_IN = 1'h0, S_AXI_WVALID_IN = 1'h0, S_AXI_BREADY_IN = 1'h0;
    logic        S_AXI_ARVALID_IN = 1'h0, S_AXI_RREADY_IN = 1'h0;
    logic        PARTNER_FORCED_IN = 1'h0, PARTNER_MASTER_IN = 1'h0;
    logic [11:0] S_AXI_AWADDR_IN = 12'h0, S_AXI_ARADDR_IN = 12'h0;
    logic [31:0] S_AXI_WDATA_IN = 32'h0, S_AXI_RDATA_OUT;
    logic [3:0]  S_AXI_WSTRB_IN = 4'hf;
    logic        S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
    logic        S_AXI_RVALID_OUT, NP_SENT_IN, RX_PAGE_VALID_IN, ANEG_RESTART_OUT;
    logic        MANUAL_EN_OUT, MANUAL_MASTER_OUT, PREFER_MASTER_OUT, ADV_FULL_OUT;
    logic        ADV_HALF_OUT, MS_FAULT_OUT;
    logic [1:0]  S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, XOVER_MODE_OUT;
    logic [2:0]  TX_TEST_MODE_OUT;
    logic [15:0] RX_PAGE_IN, TX_NP_WORD_OUT;
    wire  [33:0] act = {29'h0, MANUAL_EN_OUT, MANUAL_MASTER_OUT, PREFER_MASTER_OUT,
                        ADV_FULL_OUT, ADV_HALF_OUT};
    int          errors = 0, samples_checked = 0, m;

    anm_regs anm_regs_inst (.*);
    anm_lp_model anm_lp_model_inst (.clk_in(SYS_CLK_IN), .go_in(go), .page_in(16'ha5c3),
        .np_sent_out(NP_SENT_IN), .rx_valid_out(RX_PAGE_VALID_IN), .rx_page_out(RX_PAGE_IN));
    always #20 SYS_CLK_IN = ~SYS_CLK_IN;

    task automatic end_sim;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        int n;
        @(posedge SYS_CLK_IN);
        S_AXI_AWADDR_IN <= a;
        S_AXI_WDATA_IN <= {16'h0, d};
        S_AXI_AWVALID_IN <= 1'h1;
        S_AXI_WVALID_IN <= 1'h1;
        S_AXI_BREADY_IN <= 1'h1;
        for (n = 0; n < 20 && !S_AXI_BVALID_OUT; n++) begin
            @(posedge SYS_CLK_IN);
            if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) S_AXI_AWVALID_IN <= 1'h0;
            if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) S_AXI_WVALID_IN <= 1'h0;
        end
        if (n == 20) begin
            errors++;
            end_sim;
        end
        S_AXI_BREADY_IN <= 1'h0;
        chk({32'h0, S_AXI_BRESP_OUT}, 34'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] r);
        int n;
        @(posedge SYS_CLK_IN);
        S_AXI_ARADDR_IN <= a;
        S_AXI_ARVALID_IN <= 1'h1;
        S_AXI_RREADY_IN <= 1'h1;
        for (n = 0; n < 20 && !S_AXI_RVALID_OUT; n++) begin
            @(posedge SYS_CLK_IN);
            if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) S_AXI_ARVALID_IN <= 1'h0;
        end
        if (n == 20) begin
            errors++;
            end_sim;
        end
        S_AXI_RREADY_IN <= 1'h0;
        chk({S_AXI_RRESP_OUT, S_AXI_RDATA_OUT}, {r, 16'h0, e});
    endtask

    initial begin
        repeat (20) @(posedge SYS_CLK_IN);
        RST_N_IN <= 1'h1;
        rd(12'h01c, 16'h2001, 2'h0);
        rd(12'h020, 16'h0, 2'h0);
        rd(12'h024, 16'h0e00, 2'h0);
        wr(12'h01c, 16'hffff);
        rd(12'h01c, 16'hb7ff, 2'h0);
        go <= 1'h1;
        @(posedge SYS_CLK_IN) go <= 1'h0;
        repeat (4) @(posedge SYS_CLK_IN);
        rd(12'h01c, 16'hbfff, 2'h0);
        wr(12'h020, 16'h0);
        rd(12'h020, 16'ha5c3, 2'h0);
        wr(12'h024, 16'h3fff);
        rd(12'h024, 16'h3f00, 2'h0);
        chk(act, 34'h06);
        wr(12'h000, 16'h0200);
        repeat (2) @(posedge SYS_CLK_IN);
        chk(act, 34'h1b);
        chk({31'h0, TX_TEST_MODE_OUT}, 34'h0);
        PARTNER_FORCED_IN <= 1'h1;
        PARTNER_MASTER_IN <= 1'h1;
        rd(12'h028, 16'h8004, 2'h0);
        PARTNER_FORCED_IN <= 1'h0;
        LINK_UP_IN <= 1'h0;
        repeat (10) @(posedge SYS_CLK_IN);
        LINK_UP_IN <= 1'h1;
        repeat (10) @(posedge SYS_CLK_IN);
        wr(12'h040, 16'h0);
        wr(12'h000, 16'h8000);
        rd(12'h024, 16'h1f00, 2'h0);
        rd(12'h01c, 16'h2001, 2'h0);
        rd(12'h020, 16'h0, 2'h0);
        chk({32'h0, XOVER_MODE_OUT}, 34'h0);
        for (m = 0; m < 4; m++) begin
            wr(12'h024, {m[2:0], 13'h1f00});
            repeat (2) @(posedge SYS_CLK_IN);
            chk({31'h0, TX_TEST_MODE_OUT}, {31'h0, m[2:0]});
        end
        // Low lane only: the upper byte must keep the last test mode
        S_AXI_WSTRB_IN <= 4'h1;
        wr(12'h024, 16'h00ff);
        S_AXI_WSTRB_IN <= 4'hf;
        rd(12'h024, 16'h7f00, 2'h0);
        rd(12'h0c0, 16'h0, 2'h2);
        end_sim;
    end
endmodule
